// ==== rtl/csit_defs.svh ====
`ifndef CSIT_DEFS_SVH
`define CSIT_DEFS_SVH
// Register addresses in the special function register space
`define CSIT_ADDR_STATUS 8'hB2
`define CSIT_ADDR_TAG1 8'hBC
// Object count and highest object number
`define CSIT_NUM_OBJ 15
`define CSIT_MAX_OBJ 4'hE
// Status flag bit positions
`define CSIT_B_LENW 7
`define CSIT_B_TXD 6
`define CSIT_B_RXD 5
`define CSIT_B_BIT 4
`define CSIT_B_STF 3
`define CSIT_B_CRC 2
`define CSIT_B_FRM 1
`define CSIT_B_ACK 0
// CRC-15 generator polynomial
`define CSIT_CRC_POLY 15'h4599
// Equal-bit run that is still legal before a stuff error
`define CSIT_STUFF_RUN 3'h5
`define CSIT_RUN_ONE 3'h1
// Identifier bits carried by tag byte one, per format
`define CSIT_ID_STD_HI 10
`define CSIT_ID_STD_LO 3
`define CSIT_ID_EXT_HI 28
`define CSIT_ID_EXT_LO 21
`endif

// ==== rtl/csit_pkg.sv ====
package csit_pkg;
	// Frame field reported by the protocol engine for the current bit
	typedef enum logic [3:0] {
		CSIT_F_SOF = 4'h0,
		CSIT_F_ARB = 4'h1,
		CSIT_F_CTRL = 4'h2,
		CSIT_F_DATA = 4'h3,
		CSIT_F_CRC = 4'h4,
		CSIT_F_CRC_DELIM = 4'h5,
		CSIT_F_ACK_SLOT = 4'h6,
		CSIT_F_ACK_DELIM = 4'h7,
		CSIT_F_EOF = 4'h8,
		CSIT_F_IDLE = 4'h9,
		CSIT_F_ERROR = 4'hA
	} csit_field_t;
	// Frame tracker state
	typedef enum logic [1:0] {
		CSIT_S_IDLE = 2'b00,
		CSIT_S_TX = 2'b01,
		CSIT_S_RX = 2'b10
	} csit_fsm_t;
	// Whole state of the top module
	typedef struct packed {
		logic rx_meta;
		logic rx_bit;
		logic [14:0][7:0] status;
		logic [14:0] crc;
		logic [14:0] crc_rx;
		logic [2:0] same_cnt;
		logic last_bit;
		csit_fsm_t fsm;
		logic [3:0] obj;
		logic [7:0] rdata;
		logic rd_tag;
		logic lc_wr;
		logic [3:0] lc_obj;
		logic [3:0] lc_val;
		logic [14:0] irq;
	} csit_state_t;
endpackage

// ==== rtl/csit_tag_mem.sv ====
`timescale 1ns/1ps
// Identifier tag byte store, one byte per object, registered read
module csit_tag_mem (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic we, // Write strobe
	input wire logic [3:0] waddr, // Write object number
	input wire logic [7:0] wdata, // Write byte
	input wire logic [3:0] raddr, // Read object number
	output logic [7:0] rdata // Registered read byte
);
	// Storage has no reset: contents undefined until written
	logic [7:0] mem [0:14];

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ==== rtl/csit_top.sv ====
`timescale 1ns/1ps
`include "csit_defs.svh"
// Per-object status flags and first identifier tag byte
module csit_top (
	input wire logic clk, // System clock, 250 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic sfr_wr, // Register write strobe
	input wire logic sfr_rd, // Register read strobe
	input wire logic [7:0] sfr_wdata, // Register write data
	output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
	input wire logic [3:0] object_number, // Selected object from page register
	input wire logic can_rx, // Bus receive pin
	input wire logic can_tx_level, // Level the engine drives this bit
	input wire logic bit_strobe, // Sample point pulse
	input wire csit_pkg::csit_field_t frame_field, // Field of current bit
	input wire logic bit_is_stuff, // Current bit is a stuff bit
	input wire logic transmitting, // Node is transmitter
	input wire logic error_frame, // Node is sending an error frame
	input wire logic tx_done, // Transmission finished, pulse
	input wire logic rx_done, // Reception finished, pulse
	input wire logic [14:0] tx_enable, // Objects enabled for transmission
	input wire logic [14:0] rx_enable, // Objects enabled for reception
	input wire logic [14:0] rx_hit, // Objects matched by received frame
	input wire logic [28:0] rx_ident, // Received identifier
	input wire logic [3:0] rx_length_code, // Received length code
	input wire logic [59:0] cfg_length_code, // Configured length code per object
	input wire logic [14:0] extended_id_select, // Per-object format select
	output logic [3:0] tx_obj, // Object chosen for the current frame
	output logic length_code_wr, // Pulse: overwrite stored length code
	output logic [3:0] length_code_obj, // Object whose length code is written
	output logic [3:0] length_code, // Received length code to store
	output logic [14:0] obj_irq // Per-object interrupt request level
);
	csit_pkg::csit_state_t s_reg; // Current state
	csit_pkg::csit_state_t s_next; // Next state
	logic [14:0][7:0] ev; // Flag set events this cycle
	logic [3:0] tx_pick; // Lowest pending transmit object
	logic [3:0] rx_pick; // Lowest hit receive object
	logic [3:0] rxen_pick; // Lowest receive-enabled object
	logic bit_err_flag_ev, stuff_err_flag_ev, crc_err_flag_ev, form_err_flag_ev, ack_err_flag_ev; // Error events
	logic tag_we; // Tag byte write strobe
	logic [3:0] tag_waddr; // Tag write object
	logic [7:0] tag_wdata; // Tag write byte
	logic [7:0] tag_q; // Tag read byte
	logic [3:0] exp_lc; // Configured length code of hit object
	logic in_stuffed; // Current bit lies in the stuffed region
	logic [2:0] run_next; // Equal-bit run including this bit
	logic obj_ok; // Selected object number is in range

	// Lowest set index wins
	function automatic logic [3:0] lowest(input logic [14:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = `CSIT_NUM_OBJ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// Priority picks
	assign tx_pick = lowest(tx_enable);
	assign rx_pick = lowest(rx_hit);
	assign rxen_pick = lowest(rx_enable);
	assign exp_lc = cfg_length_code[rx_pick * 4 +: 4];
	assign obj_ok = (object_number <= `CSIT_MAX_OBJ);
	assign in_stuffed = (frame_field <= csit_pkg::CSIT_F_CRC);
	// Run count saturates one past the legal run so a long run never wraps to zero
	assign run_next = (s_reg.rx_bit != s_reg.last_bit) ? `CSIT_RUN_ONE
		: (s_reg.same_cnt > `CSIT_STUFF_RUN) ? s_reg.same_cnt
		: s_reg.same_cnt + `CSIT_RUN_ONE;

	// Tag store: received identifier has priority over a CPU write
	always_comb begin
		tag_we = 1'b0;
		tag_waddr = object_number;
		tag_wdata = sfr_wdata;
		if (rx_done && (rx_hit != 15'h0000)) begin
			tag_we = 1'b1;
			tag_waddr = rx_pick;
			// Layout follows the object's format select
			tag_wdata = extended_id_select[rx_pick] ? rx_ident[`CSIT_ID_EXT_HI:`CSIT_ID_EXT_LO]
				: rx_ident[`CSIT_ID_STD_HI:`CSIT_ID_STD_LO];
		end else if (sfr_wr && (sfr_addr == `CSIT_ADDR_TAG1) && obj_ok) begin
			tag_we = 1'b1;
		end
	end

	csit_tag_mem u_tag (
		.clk(clk),
		.rst_n(rst_n),
		.we(tag_we),
		.waddr(tag_waddr),
		.wdata(tag_wdata),
		.raddr(object_number),
		.rdata(tag_q)
	);

	// Next-state logic
	always_comb begin
		s_next = s_reg;
		ev = '0;
		bit_err_flag_ev = 1'b0;
		stuff_err_flag_ev = 1'b0;
		crc_err_flag_ev = 1'b0;
		form_err_flag_ev = 1'b0;
		ack_err_flag_ev = 1'b0;
		// Two-stage synchroniser on the bus pin
		s_next.rx_meta = can_rx;
		s_next.rx_bit = s_reg.rx_meta;
		s_next.lc_wr = 1'b0;
		if (bit_strobe) begin
			if (frame_field == csit_pkg::CSIT_F_SOF) begin
				// New frame: start CRC, run count and owner object
				s_next.crc = 15'h0000;
				s_next.same_cnt = `CSIT_RUN_ONE;
				s_next.last_bit = s_reg.rx_bit;
				s_next.fsm = transmitting ? csit_pkg::CSIT_S_TX : csit_pkg::CSIT_S_RX;
				s_next.obj = transmitting ? tx_pick : rxen_pick;
			end else if (in_stuffed && (s_reg.fsm != csit_pkg::CSIT_S_IDLE)) begin
				// Six equal bits inside the stuffed region
				s_next.same_cnt = run_next;
				s_next.last_bit = s_reg.rx_bit;
				// Flag once, on the sixth equal bit
				stuff_err_flag_ev = (run_next > `CSIT_STUFF_RUN)
					&& (s_reg.same_cnt == `CSIT_STUFF_RUN);
			end
			// CRC over destuffed bits from start of frame through data
			if (!bit_is_stuff && (frame_field <= csit_pkg::CSIT_F_DATA)) begin
				s_next.crc = {s_next.crc[13:0], 1'b0}
					^ ((s_reg.rx_bit ^ s_next.crc[14]) ? `CSIT_CRC_POLY : 15'h0000);
			end
			// Collect the received CRC field
			if (!bit_is_stuff && (frame_field == csit_pkg::CSIT_F_CRC)) begin
				s_next.crc_rx = {s_reg.crc_rx[13:0], s_reg.rx_bit};
			end
			// Compare at the CRC delimiter
			if ((frame_field == csit_pkg::CSIT_F_CRC_DELIM) && (s_reg.fsm == csit_pkg::CSIT_S_RX)) begin
				crc_err_flag_ev = (s_reg.crc != s_reg.crc_rx);
			end
			// Fixed-form bits must read recessive
			if (((frame_field == csit_pkg::CSIT_F_CRC_DELIM)
				|| (frame_field == csit_pkg::CSIT_F_ACK_DELIM)
				|| (frame_field == csit_pkg::CSIT_F_EOF))
				&& (s_reg.fsm != csit_pkg::CSIT_S_IDLE)) begin
				form_err_flag_ev = !s_reg.rx_bit;
			end
			// Transmitter sees no dominant acknowledge
			if ((frame_field == csit_pkg::CSIT_F_ACK_SLOT) && transmitting) begin
				ack_err_flag_ev = s_reg.rx_bit;
			end
			// Readback compare, transmitter only, with two exemptions
			if (transmitting && (s_reg.rx_bit != can_tx_level)) begin
				bit_err_flag_ev = 1'b1;
				if ((frame_field == csit_pkg::CSIT_F_ARB) && can_tx_level) begin
					bit_err_flag_ev = 1'b0;
				end
				if ((frame_field == csit_pkg::CSIT_F_ACK_SLOT) && !s_reg.rx_bit
					&& (error_frame || !s_reg.rx_bit)) begin
					bit_err_flag_ev = 1'b0;
				end
			end
		end
		// Errors go to the object owning the frame
		if (s_reg.fsm != csit_pkg::CSIT_S_IDLE) begin
			ev[s_reg.obj][`CSIT_B_BIT] = bit_err_flag_ev;
			ev[s_reg.obj][`CSIT_B_STF] = stuff_err_flag_ev;
			ev[s_reg.obj][`CSIT_B_CRC] = crc_err_flag_ev;
			ev[s_reg.obj][`CSIT_B_FRM] = form_err_flag_ev;
			ev[s_reg.obj][`CSIT_B_ACK] = ack_err_flag_ev;
		end
		// Successful transmission
		if (tx_done && (s_reg.fsm == csit_pkg::CSIT_S_TX)) begin
			ev[s_reg.obj][`CSIT_B_TXD] = 1'b1;
			s_next.fsm = csit_pkg::CSIT_S_IDLE;
		end
		// Successful reception updates the lowest hit object
		if (rx_done) begin
			s_next.fsm = csit_pkg::CSIT_S_IDLE;
			if (rx_hit != 15'h0000) begin
				ev[rx_pick][`CSIT_B_RXD] = 1'b1;
				ev[rx_pick][`CSIT_B_LENW] = (rx_length_code != exp_lc);
				s_next.lc_wr = 1'b1;
				s_next.lc_obj = rx_pick;
				s_next.lc_val = rx_length_code;
			end
		end
		// CPU write of the selected object's flags
		if (sfr_wr && (sfr_addr == `CSIT_ADDR_STATUS) && obj_ok) begin
			s_next.status[object_number] = sfr_wdata;
		end
		// Hardware set wins over a same-cycle clear
		for (int i = 0; i < `CSIT_NUM_OBJ; i++) begin
			s_next.status[i] = s_next.status[i] | ev[i];
			s_next.irq[i] = |s_next.status[i];
		end
		// Register read
		s_next.rd_tag = sfr_rd && (sfr_addr == `CSIT_ADDR_TAG1) && obj_ok;
		if (sfr_rd && (sfr_addr == `CSIT_ADDR_STATUS) && obj_ok) begin
			s_next.rdata = s_reg.status[object_number];
		end else begin
			s_next.rdata = 8'h00;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign sfr_rdata = s_reg.rd_tag ? tag_q : s_reg.rdata;
	assign tx_obj = s_reg.obj;
	assign length_code_wr = s_reg.lc_wr;
	assign length_code_obj = s_reg.lc_obj;
	assign length_code = s_reg.lc_val;
	assign obj_irq = s_reg.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Transmit completion sets the owner's flag
	a_tx_done_flag: assert property (
		(tx_done && s_reg.fsm == csit_pkg::CSIT_S_TX)
		|=> s_reg.status[$past(s_reg.obj)][`CSIT_B_TXD] && s_reg.fsm == csit_pkg::CSIT_S_IDLE)
		else $error("transmit done flag not set");
	// Start of frame picks the lowest pending transmitter
	a_tx_lowest_pick: assert property (
		(bit_strobe && frame_field == csit_pkg::CSIT_F_SOF && transmitting
		&& tx_enable != 15'h0000)
		|=> tx_enable[$past(tx_pick)] && tx_obj == $past(tx_pick)
		&& ($past(tx_enable) & ((15'h0001 << tx_obj) - 15'h0001)) == 15'h0000)
		else $error("transmit priority wrong");
	// Reception sets flag of the lowest hit
	a_rx_lowest_hit: assert property (
		(rx_done && rx_hit != 15'h0000)
		|=> s_reg.status[$past(rx_pick)][`CSIT_B_RXD]
		&& ($past(rx_hit) & ((15'h0001 << $past(rx_pick)) - 15'h0001)) == 15'h0000)
		else $error("receive flag or priority wrong");
	// Interrupt level follows any flag of object zero
	a_irq_follows: assert property (
		obj_irq[0] == (s_reg.status[0] != 8'h00))
		else $error("interrupt level mismatch");
	// Bit error only as transmitter on a real mismatch
	a_bit_err_tx: assert property (
		bit_err_flag_ev |-> transmitting && bit_strobe && (s_reg.rx_bit != can_tx_level))
		else $error("bit error outside transmission");
	// Arbitration loss is no bit error
	a_bit_arb_exempt: assert property (
		(bit_strobe && frame_field == csit_pkg::CSIT_F_ARB && can_tx_level)
		|-> !bit_err_flag_ev)
		else $error("bit error during arbitration loss");
	// Dominant ack slot in error frame is no bit error
	a_bit_ack_exempt: assert property (
		(bit_strobe && frame_field == csit_pkg::CSIT_F_ACK_SLOT && error_frame
		&& !s_reg.rx_bit) |-> !bit_err_flag_ev)
		else $error("bit error in ack slot");
	// CRC mismatch at delimiter raises the flag
	a_crc_err_set: assert property (
		(bit_strobe && frame_field == csit_pkg::CSIT_F_CRC_DELIM
		&& s_reg.fsm == csit_pkg::CSIT_S_RX && s_reg.crc != s_reg.crc_rx)
		|=> s_reg.status[$past(s_reg.obj)][`CSIT_B_CRC])
		else $error("crc error not flagged");
	// Dominant fixed-form bit raises form error
	a_form_err_set: assert property (
		(bit_strobe
		&& (frame_field == csit_pkg::CSIT_F_CRC_DELIM
		|| frame_field == csit_pkg::CSIT_F_ACK_DELIM
		|| frame_field == csit_pkg::CSIT_F_EOF)
		&& !s_reg.rx_bit && s_reg.fsm != csit_pkg::CSIT_S_IDLE)
		|=> s_reg.status[$past(s_reg.obj)][`CSIT_B_FRM])
		else $error("form error not flagged");
	// Stuff error only after five equal bits
	a_stuff_run: assert property (
		stuff_err_flag_ev |-> s_reg.same_cnt == `CSIT_STUFF_RUN && s_reg.rx_bit == s_reg.last_bit)
		else $error("stuff error without run");
	// Recessive ack slot as transmitter raises ack error
	a_ack_err_set: assert property (
		(bit_strobe && frame_field == csit_pkg::CSIT_F_ACK_SLOT && transmitting
		&& s_reg.rx_bit && s_reg.fsm != csit_pkg::CSIT_S_IDLE)
		|=> s_reg.status[$past(s_reg.obj)][`CSIT_B_ACK])
		else $error("ack error not flagged");
	// Length code written back one cycle after reception
	a_len_overwrite: assert property (
		(rx_done && rx_hit != 15'h0000)
		|=> length_code_wr && length_code == $past(rx_length_code) ##1 !length_code_wr)
		else $error("length code not written back");
	// Length mismatch sets the warning on the lowest hit
	a_len_warn: assert property (
		(rx_done && rx_hit != 15'h0000 && rx_length_code != exp_lc)
		|=> s_reg.status[$past(rx_pick)][`CSIT_B_LENW])
		else $error("length warning not set");
	// Readback mismatch in the data field raises the bit error flag
	a_bit_err_set: assert property (
		(bit_strobe && transmitting && frame_field == csit_pkg::CSIT_F_DATA
		&& s_reg.rx_bit != can_tx_level && s_reg.fsm == csit_pkg::CSIT_S_TX)
		|=> s_reg.status[$past(s_reg.obj)][`CSIT_B_BIT])
		else $error("bit error not flagged");
	// Standard-format reception stores identifier bits 10..3 in the tag byte
	a_tag_std_byte: assert property (
		(rx_done && rx_hit != 15'h0000 && !extended_id_select[rx_pick])
		|=> u_tag.mem[$past(rx_pick)] == $past(rx_ident[`CSIT_ID_STD_HI:`CSIT_ID_STD_LO]))
		else $error("tag byte not stored");
	// Completed reception leaves the frame tracker idle
	a_rx_idle: assert property (
		rx_done |=> s_reg.fsm == csit_pkg::CSIT_S_IDLE)
		else $error("tracker not idle after reception");

	c_tx_ok: cover property (tx_done && s_reg.fsm == csit_pkg::CSIT_S_TX);
	c_rx_warn: cover property (rx_done && rx_hit != 15'h0000 && rx_length_code != exp_lc);
	c_stuff_err: cover property (stuff_err_flag_ev);
	c_set_vs_clear: cover property (sfr_wr && sfr_addr == `CSIT_ADDR_STATUS && ev != '0);
endmodule

// ==== test/csit_node_model.sv ====
`timescale 1ns/1ps
// Other nodes on the bus, reduced to one wired-AND driver
module csit_node_model (
	input wire logic drive_en, // Far node drives a dominant or recessive bit
	input wire logic drive_level, // Level the far node puts on the bus
	input wire logic own_drive, // Our node is transmitting
	input wire logic own_level, // Level our node drives
	output logic bus // Resulting bus level, 0 is dominant
);
	// Released drivers leave the bus at the recessive pull-up level
	always_comb begin
		bus = (drive_en ? drive_level : 1'b1) & (own_drive ? own_level : 1'b1);
	end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
// Self-checking bench for the object status and tag byte block
module testbench;
	logic clk, rst_n, sfr_wr, sfr_rd, bit_strobe, bit_is_stuff, transmitting, error_frame;
	logic tx_done, rx_done, can_rx, can_tx_level, p_en, p_lvl, length_code_wr;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [3:0] object_number, rx_length_code, tx_obj, length_code_obj, length_code;
	logic [14:0] tx_enable, rx_enable, rx_hit, extended_id_select, obj_irq;
	logic [28:0] rx_ident;
	logic [59:0] cfg_length_code;
	csit_pkg::csit_field_t frame_field;
	int error_cnt = 0; // Mismatch count
	int checked = 0; // Comparison count
	// Device under test
	csit_top i_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.object_number(object_number), .can_rx(can_rx), .can_tx_level(can_tx_level),
		.bit_strobe(bit_strobe), .frame_field(frame_field), .bit_is_stuff(bit_is_stuff),
		.transmitting(transmitting), .error_frame(error_frame), .tx_done(tx_done),
		.rx_done(rx_done), .tx_enable(tx_enable), .rx_enable(rx_enable), .rx_hit(rx_hit),
		.rx_ident(rx_ident), .rx_length_code(rx_length_code),
		.cfg_length_code(cfg_length_code), .extended_id_select(extended_id_select),
		.tx_obj(tx_obj), .length_code_wr(length_code_wr), .length_code_obj(length_code_obj),
		.length_code(length_code), .obj_irq(obj_irq));
	// Far side of the bus
	csit_node_model i_node (.drive_en(p_en), .drive_level(p_lvl), .own_drive(transmitting),
		.own_level(can_tx_level), .bus(can_rx));
	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// Summary and verdict
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Register write, one-cycle strobe
	task automatic wr(input logic [3:0] obj, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		object_number <= obj;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	// Register read, data judged in the cycle after the strobe edge
	task automatic rd(input logic [3:0] obj, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk);
		object_number <= obj;
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1;
		chk(sfr_rdata & m, e);
	endtask
	// One bus bit: settle through the synchroniser, then strobe
	task automatic send_bit(input csit_pkg::csit_field_t f, input logic own, input logic pen,
		input logic plv);
		@(posedge clk);
		frame_field <= f;
		can_tx_level <= own;
		p_en <= pen;
		p_lvl <= plv;
		repeat (2) @(posedge clk);
		bit_strobe <= 1'b1;
		@(posedge clk);
		bit_strobe <= 1'b0;
	endtask
	// Completion pulse
	task automatic done_pulse(input logic is_tx);
		@(posedge clk);
		if (is_tx) tx_done <= 1'b1;
		else rx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		rx_done <= 1'b0;
	endtask
	// Read/write flags and tag, refused accesses
	task automatic test_regs();
		wr(4'h3, 8'hB2, 8'hA5);
		rd(4'h3, 8'hB2, 8'hFF, 8'hA5);
		chk(obj_irq[3], 1'b1);
		rd(4'hF, 8'hB2, 8'hFF, 8'h00);
		rd(4'h3, 8'hB3, 8'hFF, 8'h00);
		wr(4'h3, 8'hBC, 8'h3C);
		rd(4'h3, 8'hBC, 8'hFF, 8'h3C);
		wr(4'h3, 8'hB2, 8'h00);
		rd(4'h3, 8'hB2, 8'hFF, 8'h00);
		chk(obj_irq[3], 1'b0);
	endtask
	// Transmission with arbitration loss bit, bit, ack and form errors
	task automatic test_tx();
		@(posedge clk);
		tx_enable <= 15'h0024;
		transmitting <= 1'b1;
		send_bit(csit_pkg::CSIT_F_SOF, 1'b0, 1'b0, 1'b1);
		#1;
		chk(tx_obj, 4'h2);
		send_bit(csit_pkg::CSIT_F_ARB, 1'b1, 1'b1, 1'b0);
		rd(4'h2, 8'hB2, 8'h10, 8'h00);
		send_bit(csit_pkg::CSIT_F_DATA, 1'b1, 1'b1, 1'b0);
		rd(4'h2, 8'hB2, 8'h10, 8'h10);
		send_bit(csit_pkg::CSIT_F_ACK_SLOT, 1'b1, 1'b0, 1'b1);
		send_bit(csit_pkg::CSIT_F_ACK_DELIM, 1'b1, 1'b1, 1'b0);
		rd(4'h2, 8'hB2, 8'h03, 8'h03);
		done_pulse(1'b1);
		rd(4'h2, 8'hB2, 8'hFF, 8'h53);
		chk(obj_irq[2], 1'b1);
		rd(4'h5, 8'hB2, 8'hFF, 8'h00);
		@(posedge clk);
		transmitting <= 1'b0;
		tx_enable <= 15'h0000;
		wr(4'h2, 8'hB2, 8'h00);
	endtask
	// Dominant ack slot while sending an error frame
	task automatic test_err_frame();
		@(posedge clk);
		tx_enable <= 15'h0002;
		transmitting <= 1'b1;
		send_bit(csit_pkg::CSIT_F_SOF, 1'b0, 1'b0, 1'b1);
		error_frame <= 1'b1;
		send_bit(csit_pkg::CSIT_F_ACK_SLOT, 1'b1, 1'b1, 1'b0);
		rd(4'h1, 8'hB2, 8'h10, 8'h00);
		@(posedge clk);
		error_frame <= 1'b0;
		transmitting <= 1'b0;
		tx_enable <= 15'h0000;
	endtask
	// Receiver CRC mismatch, then a six-bit equal run
	task automatic test_rx_errors();
		@(posedge clk);
		rx_enable <= 15'h0050;
		send_bit(csit_pkg::CSIT_F_SOF, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 15; i++) begin
			send_bit(csit_pkg::CSIT_F_CRC, 1'b1, 1'b1, ~i[0]);
		end
		send_bit(csit_pkg::CSIT_F_CRC_DELIM, 1'b1, 1'b0, 1'b1);
		rd(4'h4, 8'hB2, 8'h06, 8'h04);
		send_bit(csit_pkg::CSIT_F_SOF, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 5; i++) begin
			send_bit(csit_pkg::CSIT_F_DATA, 1'b1, 1'b1, 1'b0);
		end
		rd(4'h4, 8'hB2, 8'h18, 8'h08);
		rd(4'h6, 8'hB2, 8'hFF, 8'h00);
		wr(4'h4, 8'hB2, 8'h00);
	endtask
	// Clean frame: bench-side CRC over SOF and a data byte must match
	task automatic test_crc_ok();
		logic [14:0] crc;
		logic [8:0] bits;
		crc = 15'h0000;
		bits = 9'h0A5;
		for (int i = 8; i >= 0; i--) begin
			if (i == 8) begin
				send_bit(csit_pkg::CSIT_F_SOF, 1'b1, 1'b1, bits[i]);
			end else begin
				send_bit(csit_pkg::CSIT_F_DATA, 1'b1, 1'b1, bits[i]);
			end
			// CRC-15 generator 4599h, zero start
			crc = {crc[13:0], 1'b0} ^ ((bits[i] ^ crc[14]) ? 15'h4599 : 15'h0000);
		end
		for (int i = 14; i >= 0; i--) begin
			send_bit(csit_pkg::CSIT_F_CRC, 1'b1, 1'b1, crc[i]);
		end
		send_bit(csit_pkg::CSIT_F_CRC_DELIM, 1'b1, 1'b0, 1'b1);
		rd(4'h4, 8'hB2, 8'h06, 8'h00);
		wr(4'h4, 8'hB2, 8'h00);
	endtask
	// Receptions: two hits with a length mismatch, then an extended frame
	task automatic test_rx_done();
		@(posedge clk);
		cfg_length_code[19:16] <= 4'h2;
		extended_id_select <= 15'h0040;
		send_bit(csit_pkg::CSIT_F_SOF, 1'b1, 1'b1, 1'b0);
		rx_hit <= 15'h0050;
		rx_ident <= 29'h000005A5;
		rx_length_code <= 4'h8;
		rx_done <= 1'b1;
		@(posedge clk);
		rx_done <= 1'b0;
		#1;
		chk(length_code_wr, 1'b1);
		chk({length_code_obj, length_code}, 8'h48);
		rd(4'h4, 8'hB2, 8'hFF, 8'hA0);
		rd(4'h4, 8'hBC, 8'hFF, 8'hB4);
		send_bit(csit_pkg::CSIT_F_SOF, 1'b1, 1'b1, 1'b0);
		rx_hit <= 15'h0040;
		rx_ident <= 29'h1ABCDEF0;
		rx_length_code <= 4'h0;
		done_pulse(1'b0);
		rd(4'h6, 8'hBC, 8'hFF, 8'hD5);
		rd(4'h6, 8'hB2, 8'hFF, 8'h20);
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{sfr_wr, sfr_rd, bit_strobe, bit_is_stuff, transmitting, error_frame} = 6'h00;
		{tx_done, rx_done, can_tx_level, p_en, p_lvl} = 5'h05;
		{sfr_addr, sfr_wdata, object_number, rx_length_code} = 24'h000000;
		{tx_enable, rx_enable, rx_hit, extended_id_select} = 60'h0;
		rx_ident = 29'h0;
		cfg_length_code = 60'h0;
		frame_field = csit_pkg::CSIT_F_IDLE;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		test_regs();
		test_tx();
		test_err_frame();
		test_rx_errors();
		test_crc_ok();
		test_rx_done();
		tally_and_finish();
	end
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#80000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
